// File: common/fsp_defines.svh
// Bit positions, sizes and timing constants of the flash status protection block
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

`define FSP_SR_WIP          0
`define FSP_SR_WEL          1
`define FSP_SR_BP_LSB       2
`define FSP_SR_BP_MSB       6
`define FSP_SR_STATUS_PROTECT_BIT_LOW         7
`define FSP_SR_STATUS_PROTECT_BIT_HIGH         8
`define FSP_SR_QE           9
`define FSP_SR_LB0          10
`define FSP_SR_LB1          11
`define FSP_SR_DC           12
`define FSP_SR_RSVD         13
`define FSP_SR_CMP          14
`define FSP_SR_SUS          15

`define FSP_NV_MASK         16'h5ffc
`define FSP_NV_RESET        16'h0000
`define FSP_WRITE_KEEP_HIGH 16'h00ff

`define FSP_ADDR_W          21
`define FSP_SPAN_W          22
`define FSP_ARRAY_BYTES     22'h200000
`define FSP_LARGE_UNIT      22'h010000
`define FSP_SMALL_UNIT      22'h001000

`define FSP_BP_NONE         3'h0
`define FSP_BP_ALL_HI       2'h3
`define FSP_BP_CHIP_FREE1   3'h7
`define FSP_BP_SMALL_CAP    3'h4
`define FSP_BP_ONE          3'h1

`define FSP_SRP_HW          2'h1

`define FSP_CLK_PERIOD_NS   20
`define FSP_SRW_TIME_NS     5000000
`define FSP_SRW_CNT_W       20
`define FSP_SRW_CNT_ONE     20'h00001

`endif

// File: common/fsp_pkg.sv
// Types shared by the flash status protection block
package fsp_pkg;

  typedef enum logic [3:0] {
    OP_NOP                     = 4'h0,
    OP_WRITE_ENABLE_COMMAND    = 4'h1,
    OP_WRITE_DISABLE_COMMAND   = 4'h2,
    OP_WRITE_STATUS_COMMAND    = 4'h3,
    OP_PAGE_PROGRAM_COMMAND    = 4'h4,
    OP_SMALL_REGION_ERASE      = 4'h5,
    OP_BLOCK_ERASE_COMMAND_32K = 4'h6,
    OP_BLOCK_ERASE_COMMAND_64K = 4'h7,
    OP_CHIP_ERASE              = 4'h8,
    OP_SUSPEND                 = 4'h9,
    OP_RESUME                  = 4'ha,
    OP_SOFT_RESET              = 4'hb
  } fsp_op_e;

  typedef enum logic [1:0] {
    ST_IDLE         = 2'b00,
    ST_ARRAY        = 2'b01,
    ST_STATUS_WRITE = 2'b10,
    ST_PAUSED       = 2'b11
  } fsp_state_e;

  typedef struct packed {
    fsp_op_e     op;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic        two_byte;
  } fsp_cmd_s;

  typedef struct packed {
    fsp_op_e     op;
    logic [20:0] addr;
  } fsp_array_req_s;

endpackage

// File: rtl/fsp_nv_store.sv
// Non-volatile status bit store with registered read data
`timescale 1ns/10ps
`include "fsp_defines.svh"

module fsp_nv_store (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_data_i,
  output logic      [15:0] rd_data_o
);

  logic [15:0] store_r;
  logic [15:0] store_nxt;
  logic [15:0] rd_r;
  logic [15:0] rd_nxt;

  // Reserved and volatile positions never hold a value, so they read as zero
  always_comb begin
    store_nxt = store_r;
    if (wr_en_i) begin
      store_nxt = wr_data_i & `FSP_NV_MASK;
    end
    rd_nxt = store_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      store_r <= `FSP_NV_RESET;
      rd_r    <= `FSP_NV_RESET;
    end else begin
      store_r <= store_nxt;
      rd_r    <= rd_nxt;
    end
  end

  assign rd_data_o = rd_r;

endmodule

// File: rtl/fsp_status_protect.sv
// Status register pair, write-enable latch and array protection decode
// Operation
// [RL1] Complement bit inverts the protected range
// [RL2] Complement with top field bit leaves small region
// [RL3] First status byte layout, latch and busy read-only
// [RL4] Second status byte layout, suspend flag read-only
// [RL5] Lock bits are one-time set, never cleared
// [RL6] Two status protect bits held non-volatile, writable
// [RL7] Busy reads 1 during program, erase, status write
// [RL8] Latch bit mirrors the internal write-enable latch
// [RL9] Latch clear rejects status write, program, erase
// [RL10] Protect field changes only by status write
// [RL11] Program and erase refused inside protected range
// [RL12] Protect field write blocked under hardware protection
// [RL13] Field selects top or bottom fractions or sectors
// [RL14] Latch set by enable, cleared by listed commands
// [RL15] Write-protect pin low locks field and protect bits
// [RL16] Chip erase only when nothing is protected
// [RL17] Decode uses current contents at command time
// [RL18] Host polls busy before next write command
`timescale 1ns/10ps
`include "fsp_defines.svh"

module fsp_status_protect #(
  parameter int unsigned SRW_CYCLES = `FSP_SRW_TIME_NS / `FSP_CLK_PERIOD_NS
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     cmd_valid_i,
  input  wire fsp_pkg::fsp_cmd_s        cmd_i,
  input  wire logic                     write_protect_n_i,
  input  wire logic                     array_done_i,
  output logic                          cmd_done_o,
  output logic                          cmd_refused_o,
  output logic                          array_go_o,
  output fsp_pkg::fsp_array_req_s       array_req_o,
  output logic                          array_pause_o,
  output logic [7:0]                    protection_status_low_o,
  output logic [7:0]                    protection_status_high_o
);
  import fsp_pkg::*;

  // True when the address lies in the area selected by field and complement
  function automatic logic prot_hit(input logic [4:0]              bp,
                                    input logic                    cmp,
                                    input logic [`FSP_ADDR_W-1:0]  addr);
    logic [2:0]             n;
    logic [`FSP_SPAN_W-1:0] span;
    logic [`FSP_SPAN_W-1:0] addr_w;
    logic                   hit;
    n      = (bp[4] && bp[2]) ? `FSP_BP_SMALL_CAP : bp[2:0];
    span   = (bp[4] ? `FSP_SMALL_UNIT : `FSP_LARGE_UNIT) << (n - `FSP_BP_ONE);
    addr_w = {1'b0, addr};
    if (bp[2:0] == `FSP_BP_NONE) begin
      hit = 1'b0;
    end else if (bp[2:1] == `FSP_BP_ALL_HI) begin
      hit = 1'b1;
    end else if (!bp[3]) begin
      hit = (addr_w >= (`FSP_ARRAY_BYTES - span)); // see [RL13] see [RL2]
    end else begin
      hit = (addr_w < span); // see [RL13] see [RL2]
    end
    return hit ^ cmp; // see [RL1]
  endfunction

  // Write-protect pin synchroniser
  logic wp_meta_r;
  logic wp_sync_r;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wp_meta_r <= 1'b1;
      wp_sync_r <= 1'b1;
    end else begin
      wp_meta_r <= write_protect_n_i;
      wp_sync_r <= wp_meta_r;
    end
  end

  // Non-volatile bits
  logic        nv_wr_en;
  logic [15:0] nv_wr_data;
  logic [15:0] nv_rd;

  fsp_nv_store u_nv_store (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (nv_wr_en),
    .wr_data_i (nv_wr_data),
    .rd_data_o (nv_rd)
  );

  logic [4:0] block_protect_field;
  logic       complement_protect_bit;
  logic [1:0] status_protect_bits;
  logic       security_lock_bit_high;
  logic       security_lock_bit_low;
  logic       status_locked;
  logic       chip_free;

  assign block_protect_field    = nv_rd[`FSP_SR_BP_MSB:`FSP_SR_BP_LSB];
  assign complement_protect_bit = nv_rd[`FSP_SR_CMP];
  assign status_protect_bits    = {nv_rd[`FSP_SR_STATUS_PROTECT_BIT_HIGH], nv_rd[`FSP_SR_STATUS_PROTECT_BIT_LOW]};
  assign security_lock_bit_high = nv_rd[`FSP_SR_LB1];
  assign security_lock_bit_low  = nv_rd[`FSP_SR_LB0];

  // Hardware mode with the pin low, power lock-down and one-time mode all lock
  assign status_locked = ((status_protect_bits == `FSP_SRP_HW) && !wp_sync_r)
                         || status_protect_bits[1]; // see [RL12] see [RL15]

  assign chip_free = ((block_protect_field[2:0] == `FSP_BP_NONE) && !complement_protect_bit)
                  || ((block_protect_field[2:0] == `FSP_BP_CHIP_FREE1)
                      && complement_protect_bit); // see [RL16]

  // Command sequencer state
  fsp_state_e                 state_r;
  fsp_state_e                 state_nxt;
  logic                       write_enable_latch_r;
  logic                       write_enable_latch_nxt;
  logic                       paused_operation_flag_r;
  logic                       paused_operation_flag_nxt;
  logic [`FSP_SRW_CNT_W-1:0]  srw_cnt_r;
  logic [`FSP_SRW_CNT_W-1:0]  srw_cnt_nxt;
  logic                       done_r;
  logic                       done_nxt;
  logic                       refused_r;
  logic                       refused_nxt;
  logic                       go_r;
  logic                       go_nxt;
  fsp_array_req_s             req_r;
  fsp_array_req_s             req_nxt;
  logic                       pause_r;
  logic                       pause_nxt;
  logic                       target_hit;
  logic [15:0]                wr_merge;

  always_comb begin
    state_nxt                 = state_r;
    write_enable_latch_nxt    = write_enable_latch_r;
    paused_operation_flag_nxt = paused_operation_flag_r;
    srw_cnt_nxt               = srw_cnt_r;
    done_nxt                  = 1'b0;
    refused_nxt               = 1'b0;
    go_nxt                    = 1'b0;
    req_nxt                   = req_r;
    pause_nxt                 = pause_r;
    nv_wr_en                  = 1'b0;
    nv_wr_data                = nv_rd;
    target_hit = prot_hit(block_protect_field, complement_protect_bit,
                          cmd_i.addr); // see [RL17]
    // A single-byte status write leaves the second byte as it stands
    wr_merge = cmd_i.two_byte ? cmd_i.wdata
             : ((cmd_i.wdata & `FSP_WRITE_KEEP_HIGH) | (nv_rd & ~`FSP_WRITE_KEEP_HIGH));

    case (state_r)
      ST_ARRAY: begin
        if (array_done_i) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_STATUS_WRITE: begin
        if (srw_cnt_r <= `FSP_SRW_CNT_ONE) begin
          state_nxt = ST_IDLE;
        end else begin
          srw_cnt_nxt = srw_cnt_r - `FSP_SRW_CNT_ONE;
        end
      end
      default: begin
      end
    endcase

    if (cmd_valid_i) begin
      done_nxt = 1'b1;
      case (cmd_i.op)
        OP_SOFT_RESET: begin
          state_nxt                 = ST_IDLE;
          write_enable_latch_nxt    = 1'b0; // see [RL14]
          paused_operation_flag_nxt = 1'b0;
          pause_nxt                 = 1'b0;
        end
        OP_SUSPEND: begin
          if (state_r == ST_ARRAY && !array_done_i) begin
            state_nxt                 = ST_PAUSED;
            paused_operation_flag_nxt = 1'b1;
            pause_nxt                 = 1'b1;
          end else begin
            done_nxt    = 1'b0;
            refused_nxt = 1'b1;
          end
        end
        OP_RESUME: begin
          if (state_r == ST_PAUSED) begin
            state_nxt                 = ST_ARRAY;
            paused_operation_flag_nxt = 1'b0;
            pause_nxt                 = 1'b0;
          end else begin
            done_nxt    = 1'b0;
            refused_nxt = 1'b1;
          end
        end
        OP_NOP: begin
        end
        default: begin
          if (state_r == ST_ARRAY || state_r == ST_STATUS_WRITE) begin
            // Busy device takes nothing new; see [RL18]
            done_nxt    = 1'b0;
            refused_nxt = 1'b1;
          end else begin
            case (cmd_i.op)
              OP_WRITE_ENABLE_COMMAND: begin
                write_enable_latch_nxt = 1'b1; // see [RL14]
              end
              OP_WRITE_DISABLE_COMMAND: begin
                write_enable_latch_nxt = 1'b0; // see [RL14]
              end
              OP_WRITE_STATUS_COMMAND: begin
                write_enable_latch_nxt = 1'b0; // see [RL14]
                if (!write_enable_latch_r || status_locked) begin
                  done_nxt    = 1'b0; // see [RL9] see [RL12] see [RL15]
                  refused_nxt = 1'b1;
                end else begin
                  nv_wr_en   = 1'b1; // see [RL10] see [RL6]
                  nv_wr_data = wr_merge;
                  nv_wr_data[`FSP_SR_LB1] = wr_merge[`FSP_SR_LB1]
                                            | security_lock_bit_high; // see [RL5]
                  nv_wr_data[`FSP_SR_LB0] = wr_merge[`FSP_SR_LB0]
                                            | security_lock_bit_low;  // see [RL5]
                  state_nxt   = ST_STATUS_WRITE;
                  srw_cnt_nxt = `FSP_SRW_CNT_W'(SRW_CYCLES);
                end
              end
              OP_PAGE_PROGRAM_COMMAND, OP_SMALL_REGION_ERASE,
              OP_BLOCK_ERASE_COMMAND_32K, OP_BLOCK_ERASE_COMMAND_64K,
              OP_CHIP_ERASE: begin
                write_enable_latch_nxt = 1'b0; // see [RL14]
                if (!write_enable_latch_r) begin
                  done_nxt    = 1'b0; // see [RL9]
                  refused_nxt = 1'b1;
                end else if ((cmd_i.op == OP_CHIP_ERASE) ? !chip_free : target_hit) begin
                  done_nxt    = 1'b0; // see [RL11] see [RL16]
                  refused_nxt = 1'b1;
                end else begin
                  state_nxt   = ST_ARRAY;
                  go_nxt      = 1'b1;
                  req_nxt.op   = cmd_i.op;
                  req_nxt.addr = cmd_i.addr;
                end
              end
              default: begin
                done_nxt    = 1'b0;
                refused_nxt = 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_r                 <= ST_IDLE;
      write_enable_latch_r    <= 1'b0; // see [RL14]
      paused_operation_flag_r <= 1'b0;
      srw_cnt_r               <= '0;
      done_r                  <= 1'b0;
      refused_r               <= 1'b0;
      go_r                    <= 1'b0;
      req_r                   <= '0;
      pause_r                 <= 1'b0;
    end else begin
      state_r                 <= state_nxt;
      write_enable_latch_r    <= write_enable_latch_nxt;
      paused_operation_flag_r <= paused_operation_flag_nxt;
      srw_cnt_r               <= srw_cnt_nxt;
      done_r                  <= done_nxt;
      refused_r               <= refused_nxt;
      go_r                    <= go_nxt;
      req_r                   <= req_nxt;
      pause_r                 <= pause_nxt;
    end
  end

  // Status bytes as the host reads them; one cycle behind the internal state
  logic       write_in_progress_flag;
  logic [7:0] status_low_r;
  logic [7:0] status_low_nxt;
  logic [7:0] status_high_r;
  logic [7:0] status_high_nxt;

  // A suspended operation does not count as busy
  assign write_in_progress_flag = (state_r == ST_ARRAY)
                                || (state_r == ST_STATUS_WRITE); // see [RL7]

  always_comb begin
    status_low_nxt  = nv_rd[7:0];
    status_low_nxt[`FSP_SR_WIP] = write_in_progress_flag; // see [RL3] see [RL7]
    status_low_nxt[`FSP_SR_WEL] = write_enable_latch_r;   // see [RL3] see [RL8]
    status_high_nxt = nv_rd[15:8];
    status_high_nxt[`FSP_SR_SUS - 8] = paused_operation_flag_r; // see [RL4]
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      status_low_r  <= 8'h00;
      status_high_r <= 8'h00;
    end else begin
      status_low_r  <= status_low_nxt;
      status_high_r <= status_high_nxt;
    end
  end

  assign protection_status_low_o  = status_low_r;
  assign protection_status_high_o = status_high_r;
  assign cmd_done_o               = done_r;
  assign cmd_refused_o            = refused_r;
  assign array_go_o               = go_r;
  assign array_req_o              = req_r;
  assign array_pause_o            = pause_r;

endmodule

// File: sim/fsp_status_protect_asserts.sv
// Port-level assertions for the status protection block
`timescale 1ns/10ps
module fsp_status_protect_asserts (
  input wire logic                    ref_clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    cmd_valid_i,
  input wire fsp_pkg::fsp_cmd_s       cmd_i,
  input wire logic                    write_protect_n_i,
  input wire logic                    array_done_i,
  input wire logic                    cmd_done_o,
  input wire logic                    cmd_refused_o,
  input wire logic                    array_go_o,
  input wire fsp_pkg::fsp_array_req_s array_req_o,
  input wire logic                    array_pause_o,
  input wire logic [7:0]              protection_status_low_o,
  input wire logic [7:0]              protection_status_high_o
);
  import fsp_pkg::*;
  wire [7:0] lo = protection_status_low_o;
  wire [7:0] hi = protection_status_high_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_answer_one: assert property (cmd_valid_i |=> cmd_done_o ^ cmd_refused_o)
    else $error("command not answered exactly once");
  a_go_done: assert property (array_go_o |-> cmd_done_o)
    else $error("array start without done");
  a_busy_go: assert property (array_go_o |=> lo[0])
    else $error("busy missing after array start");
  a_latch_set: assert property (
    cmd_valid_i && cmd_i.op == OP_WRITE_ENABLE_COMMAND ##1 cmd_done_o |=> lo[1])
    else $error("latch not set by enable");
  a_latch_clr: assert property (
    cmd_valid_i && cmd_i.op inside {[OP_WRITE_STATUS_COMMAND:OP_CHIP_ERASE]} |-> ##2 !lo[1])
    else $error("latch not cleared");
  a_lock_keep: assert property ((hi[3:2] & $past(hi[3:2])) == $past(hi[3:2]))
    else $error("lock bit returned to zero");
  a_rsvd_zero: assert property (hi[5] == 1'b0)
    else $error("reserved bit set");
  a_field_src: assert property (
    $changed({lo[6:2], hi[6]}) |-> $past(cmd_valid_i && cmd_i.op == OP_WRITE_STATUS_COMMAND, 3))
    else $error("protect field changed without status write");
  a_pause_sus: assert property ($rose(array_pause_o) |=> hi[7] && !lo[0])
    else $error("suspend flag or busy wrong when paused");
  c_go: cover property (array_go_o);
  c_refused: cover property (cmd_refused_o);
  c_pause: cover property ($rose(array_pause_o));
  c_write_status_command: cover property (cmd_valid_i && cmd_i.op == OP_WRITE_STATUS_COMMAND ##1 cmd_done_o);
endmodule

bind fsp_status_protect fsp_status_protect_asserts u_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .write_protect_n_i(write_protect_n_i), .array_done_i(array_done_i),
  .cmd_done_o(cmd_done_o), .cmd_refused_o(cmd_refused_o), .array_go_o(array_go_o),
  .array_req_o(array_req_o), .array_pause_o(array_pause_o),
  .protection_status_low_o(protection_status_low_o),
  .protection_status_high_o(protection_status_high_o));

// File: sim/fsp_array_model.sv
// Array engine model answering program and erase starts
`timescale 1ns/10ps
module fsp_array_model (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic go_i,
  input  wire logic pause_i,
  input  wire logic slow_i,
  output logic      done_o
);
  logic [4:0] cnt_r, cnt_nxt;
  logic       done_r, done_nxt;
  assign done_o = done_r;
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (go_i) begin
      cnt_nxt = slow_i ? 5'h14 : 5'h02;
    end else if (cnt_r != 5'h00 && !pause_i) begin
      // Paused work must not finish, so the count freezes
      cnt_nxt = cnt_r - 5'h01;
      done_nxt = (cnt_r == 5'h01);
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= 5'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
endmodule

// File: sim/tb_flash_status_protection.sv
// Self-checking bench for the status protection block
`timescale 1ns/10ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %0t %s", $time, m); end end
module tb_flash_status_protection;
  import fsp_pkg::*;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i = 1'b0, wp_n = 1'b1, slow = 1'b0;
  logic           one_byte = 1'b0;
  fsp_cmd_s       cmd_i = '0;
  logic           cmd_done_o, cmd_refused_o, array_go_o, array_pause_o, array_done;
  fsp_array_req_s array_req_o;
  logic [7:0]     lo, hi;
  int             miscompares = 0, tests_run = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  fsp_status_protect #(.SRW_CYCLES(8)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .write_protect_n_i(wp_n),
    .array_done_i(array_done), .cmd_done_o(cmd_done_o), .cmd_refused_o(cmd_refused_o),
    .array_go_o(array_go_o), .array_req_o(array_req_o), .array_pause_o(array_pause_o),
    .protection_status_low_o(lo), .protection_status_high_o(hi));
  fsp_array_model model_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .go_i(array_go_o),
    .pause_i(array_pause_o), .slow_i(slow), .done_o(array_done));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic send(input fsp_op_e op, input logic [20:0] a, input logic [15:0] wd,
                      output logic ok);
    int k;
    cmd_i = '{op: op, addr: a, wdata: wd, two_byte: !one_byte};
    cmd_valid_i = 1'b1;
    step();
    cmd_valid_i = 1'b0;
    for (k = 0; k < 3 && cmd_done_o !== 1'b1 && cmd_refused_o !== 1'b1; k++) step();
    if (k == 3) begin
      $display("FAIL %0t command not answered", $time);
      miscompares++;
      test_done();
    end else begin
      ok = cmd_done_o;
      // One idle edge keeps the next request out of this time step
      step();
    end
  endtask
  // Host waits for busy to drop before the next write command
  task automatic idle();
    int k;
    step();
    step();
    for (k = 0; k < 100 && lo[0] !== 1'b0; k++) step();
    if (k == 100) begin
      $display("FAIL %0t busy never dropped", $time);
      miscompares++;
      test_done();
    end
  endtask
  task automatic write_enable_command();
    logic ok;
    send(OP_WRITE_ENABLE_COMMAND, 21'h0, 16'h0, ok);
    `CHK(ok, 1'b1, "enable")
    step();
  endtask
  task automatic write_status_command(input logic [15:0] wd, input logic e);
    logic ok;
    write_enable_command();
    send(OP_WRITE_STATUS_COMMAND, 21'h0, wd, ok);
    `CHK(ok, e, "status write")
    idle();
  endtask
  task automatic t_latch();
    logic ok;
    `CHK({hi, lo}, 16'h0000, "reset status")
    send(OP_PAGE_PROGRAM_COMMAND, 21'h0, 16'h0, ok);
    `CHK(ok, 1'b0, "program without latch")
    write_enable_command();
    `CHK(lo[1], 1'b1, "latch set")
    send(OP_WRITE_DISABLE_COMMAND, 21'h0, 16'h0, ok);
    step();
    `CHK(lo[1], 1'b0, "latch cleared")
    write_enable_command();
    send(OP_SOFT_RESET, 21'h0, 16'h0, ok);
    `CHK(lo[1], 1'b0, "latch cleared by soft reset")
  endtask
  task automatic t_status();
    logic ok;
    write_enable_command();
    // Volatile and reserved bits are set in the data to prove they are ignored
    send(OP_WRITE_STATUS_COMMAND, 21'h0, 16'hbe7f, ok);
    step();
    `CHK(lo[0], 1'b1, "busy in status write")
    idle();
    `CHK(lo, 8'h7c, "low byte")
    `CHK(hi, 8'h1e, "high byte")
    write_status_command(16'h0000, 1'b1);
    `CHK({hi, lo}, 16'h0c00, "locks kept")
    // A first-byte-only write must leave the complement bit untouched
    one_byte = 1'b1;
    write_status_command(16'h4010, 1'b1);
    `CHK({hi, lo}, 16'h0c10, "one byte write")
    one_byte = 1'b0;
  endtask
  task automatic t_table();
    logic [3:0]  opc[13] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h4, 4'h4,
                             4'h8, 4'h8, 4'h8};
    logic [4:0]  fld[13] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h11, 5'h11, 5'h1a, 5'h1a, 5'h00,
                             5'h06, 5'h00, 5'h01, 5'h07};
    logic        cmpv[13] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                              1'b0, 1'b0, 1'b1};
    logic [20:0] adr[13] = '{21'h1f0000, 21'h1effff, 21'h1f0000, 21'h1effff, 21'h1ff000,
                             21'h1fefff, 21'h001fff, 21'h002000, 21'h0, 21'h0, 21'h0, 21'h0,
                             21'h0};
    logic        acc[13] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
                             1'b1, 1'b0, 1'b1};
    logic        ok;
    for (int i = 0; i < 13; i++) begin
      write_status_command({1'b0, cmpv[i], 6'h00, 1'b0, fld[i], 2'b00}, 1'b1);
      write_enable_command();
      send(fsp_op_e'(opc[i]), adr[i], 16'h0, ok);
      `CHK(ok, acc[i], "protect decode")
      if (ok) `CHK(array_req_o, {opc[i], adr[i]}, "start request")
      idle();
      `CHK(lo[1], 1'b0, "latch after array command")
    end
  endtask
  task automatic t_suspend();
    logic ok;
    slow = 1'b1;
    write_enable_command();
    send(OP_PAGE_PROGRAM_COMMAND, 21'h012345, 16'h0, ok);
    step();
    send(OP_SUSPEND, 21'h0, 16'h0, ok);
    `CHK(ok & array_pause_o, 1'b1, "suspend")
    step();
    `CHK({hi[7], lo[0]}, 2'b10, "paused status")
    send(OP_RESUME, 21'h0, 16'h0, ok);
    `CHK(array_pause_o, 1'b0, "resume")
    idle();
    `CHK(hi[7], 1'b0, "suspend flag cleared")
    slow = 1'b0;
  endtask
  task automatic t_protect();
    write_status_command(16'h0084, 1'b1);
    wp_n = 1'b0;
    repeat (3) step();
    write_status_command(16'h0008, 1'b0);
    `CHK(lo, 8'h84, "field held by pin")
    wp_n = 1'b1;
    repeat (3) step();
    write_status_command(16'h0008, 1'b1);
    `CHK(lo, 8'h08, "protect bit low cleared")
    write_status_command(16'h0100, 1'b1);
    `CHK(hi[0], 1'b1, "protect bit high set")
    write_status_command(16'h0000, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    step();
    t_latch();
    t_status();
    t_table();
    t_suspend();
    t_protect();
    test_done();
  end
endmodule
